// [rtl/adcc_params.svh]
// timing counts, register offsets, field positions and reset values of the converter control
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// register offsets (serial address A6..A0)
`define ADCC_REG_CFG0       7'h00
`define ADCC_REG_CFG1       7'h01
`define ADCC_REG_OVR        7'h02
`define ADCC_REG_CORR       7'h03
`define ADCC_REG_CORR2      7'h1A
`define ADCC_REG_SRST       7'h2C
`define ADCC_REG_PWR        7'h37
`define ADCC_REG_TPA        7'h3C
`define ADCC_REG_TPB        7'h3D
`define ADCC_REG_TPC        7'h3E

// field positions
`define ADCC_CFG0_DEC_EN    14
`define ADCC_CFG0_HPF       12
`define ADCC_CFG1_CORR_EN   15
`define ADCC_CFG1_FMT       3
`define ADCC_CFG1_HP1       1
`define ADCC_OVR_LSB        7
`define ADCC_OVR_MSB        10
`define ADCC_CORR_START     14
`define ADCC_CORR2_RST      0
`define ADCC_SRST_BIT       0
`define ADCC_PWR_LSB        0
`define ADCC_PWR_MSB        1
`define ADCC_TP_EN          15
`define ADCC_TP_LSB         2
`define ADCC_TP_MSB         13

// reset values
`define ADCC_RST_CFG0       16'h0000
`define ADCC_RST_CFG1       16'h0002
`define ADCC_RST_OVR        16'h0780
`define ADCC_RST_CORR       16'h0B18
`define ADCC_RST_CORR2      16'h0000
`define ADCC_RST_PWR        16'h0000
`define ADCC_RST_TP         16'h0000

// timing
`define ADCC_CLK_MHZ        25
`define ADCC_T_SHUT_NS      2500000
`define ADCC_T_STBY_NS      100000
`define ADCC_T_DEEP_NS      20000
`define ADCC_T_LIGHT_NS     2000
`define ADCC_OVR_LAT        12
`define ADCC_SIF_BITS       24
`define ADCC_CORR_SHIFT     10

`endif

// [rtl/adcc_pkg.sv]
// types shared by the converter control modules
package adcc_pkg;

	// low-power state chosen by software, in register order
	typedef enum logic [1:0] {
		PWR_STANDBY,
		PWR_LIGHT,
		PWR_DEEP,
		PWR_SHUTDOWN
	} adcc_pwr_t;

	// power sequencing states
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_WAKE
	} adcc_state_t;

	// one result from each sub-converter, a taken first
	typedef struct packed {
		logic [11:0] b;
		logic [11:0] a;
	} adcc_pair_t;

endpackage

// [rtl/adcc_fifo.sv]
// small fifo with registered read data and registered ready
`timescale 1ns/100ps
`default_nettype none
module adcc_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// draining side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;

	// push into memory, move the head into the output register
	wire push = in_valid & in_ready;
	wire load = (cnt_q != '0) & (~out_valid | out_ready);

	assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

	// memory array, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers, fill level and flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_q      <= push ? wr_q + 1'b1 : wr_q;
			rd_q      <= load ? rd_q + 1'b1 : rd_q;
			cnt_q     <= cnt_d;
			in_ready  <= (cnt_d < (AW+1)'(DEPTH));  // honest full
			out_valid <= load | (out_valid & ~out_ready);
			if (load) begin
				out_data <= mem[rd_q];
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/adcc_halfband.sv]
// decimate-by-two half-band filter with low-pass or high-pass response
`timescale 1ns/100ps
`default_nettype none
module adcc_halfband #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// control
	input  wire logic                hpf,
	// sample in
	input  wire logic                in_valid,
	input  wire logic signed [W-1:0] in_data,
	// decimated sample out
	output logic                     out_valid,
	output logic signed [W-1:0]      out_data
);
	localparam int SW = W + 7;
	// coefficients and clip limits at full accumulator width, all signed
	localparam logic signed [SW-1:0] K9    = (SW)'(9);
	localparam logic signed [SW-1:0] K16   = (SW)'(16);
	localparam logic signed [SW-1:0] Y_MAX = (SW)'((1 << (W - 1)) - 1);
	localparam logic signed [SW-1:0] Y_MIN = (SW)'(-(1 << (W - 1)));

	logic signed [W-1:0]  tap_q [7];
	logic                 mod_q;
	logic                 dec_q;
	logic signed [SW-1:0] acc;
	logic signed [SW-1:0] scl;

	// high-pass: shift the band by fs/2 through sign alternation before the low-pass
	wire signed [W-1:0] x_in = (hpf & mod_q) ? -in_data : in_data;

	// taps -1 0 9 16 9 0 -1, sum 32
	assign acc = (SW)'(tap_q[2]) * K9 + (SW)'(tap_q[3]) * K16 + (SW)'(tap_q[4]) * K9
		- (SW)'(tap_q[0]) - (SW)'(tap_q[6]);
	assign scl = acc >>> 5;

	// signed compares only, an unsigned limit would clip every small sample
	wire sat_hi = scl > Y_MAX;
	wire sat_lo = scl < Y_MIN;
	wire signed [W-1:0] y = sat_hi ? Y_MAX[W-1:0] :
		sat_lo ? Y_MIN[W-1:0] : scl[W-1:0];

	// delay line and one output every second input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 7; i++) tap_q[i] <= '0;
			mod_q     <= 1'b0;
			dec_q     <= 1'b0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= 1'b0;
			if (in_valid) begin
				tap_q[0] <= x_in;
				for (int i = 1; i < 7; i++) tap_q[i] <= tap_q[i-1];
				mod_q <= ~mod_q;
				dec_q <= ~dec_q;
				if (dec_q) begin
					out_valid <= 1'b1;
					out_data  <= y;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/adcc_top.sv]
// converter digital control: serial registers, power states, data path, test patterns, over-range
`timescale 1ns/100ps
`default_nettype none
`include "adcc_params.svh"
module adcc_top
	import adcc_pkg::*;
#(
	parameter int          FIFO_DEPTH    = 16,
	parameter logic [16:0] WAKE_SHUT_CYC =
		17'((`ADCC_T_SHUT_NS * `ADCC_CLK_MHZ + 999) / 1000)
) (
	// clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RST_N,
	// power control pin
	input  wire logic       ENABLE,
	// serial register port
	input  wire logic       SIF_EN_N,
	input  wire logic       SIF_CLK,
	input  wire logic       SIF_DIN,
	output logic            SIF_DOUT,
	output logic            SIF_DOUT_OE,
	// sub-converter results
	input  wire logic       SUB_VALID,
	input  wire adcc_pair_t SUB_DATA,
	output logic            SUB_READY,
	// sample output
	output logic [11:0]     DOUT,
	output logic            DOUT_VALID,
	output logic            OVR_FLAG,
	output logic            AWAKE
);
	localparam logic [16:0] WAKE_STBY  = 17'((`ADCC_T_STBY_NS * `ADCC_CLK_MHZ + 999) / 1000);
	localparam logic [16:0] WAKE_DEEP  = 17'((`ADCC_T_DEEP_NS * `ADCC_CLK_MHZ + 999) / 1000);
	localparam logic [16:0] WAKE_LIGHT = 17'((`ADCC_T_LIGHT_NS * `ADCC_CLK_MHZ + 999) / 1000);
	localparam logic [4:0]  LAST_BIT   = 5'(`ADCC_SIF_BITS - 1);

	// pin synchronisers: enable pin, serial enable, serial clock, serial data
	logic [3:0]  pin_s1_q, pin_s2_q, pin_s3_q, lvl_q;
	logic [3:0]  lvl_d;
	// registers
	logic [15:0] cfg0_q, cfg1_q, ovr_q, corr_q, corr2_q, pwr_q, tpa_q, tpb_q, tpc_q;
	// serial engine
	logic [4:0]  bit_q;
	logic [22:0] sh_q;
	logic        rw_q;
	logic [15:0] sdo_q;
	// power sequencing
	adcc_state_t st_q;
	logic [16:0] wake_q;
	// data path
	logic        phase_q, raw_v_q, c_v_q, tog_q;
	logic signed [11:0] raw_q, c_q;
	logic signed [19:0] est_a_q, est_b_q;
	logic        raw_lane_q;
	logic [`ADCC_OVR_LAT-2:0] ovr_pipe_q;

	// a level change counts once the second and third stages agree
	assign lvl_d = (pin_s2_q & pin_s3_q) | (lvl_q & (pin_s2_q | pin_s3_q));
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1_q <= 4'hF;
			pin_s2_q <= 4'hF;
			pin_s3_q <= 4'hF;
			lvl_q    <= 4'hF;
		end else begin
			pin_s1_q <= {SIF_DIN, SIF_CLK, SIF_EN_N, ENABLE};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			lvl_q    <= lvl_d;
		end
	end

	wire en_pin   = lvl_q[0];
	wire sif_act  = ~lvl_q[1];
	wire sclk_up  = sif_act & lvl_d[2] & ~lvl_q[2];
	wire sclk_dn  = sif_act & ~lvl_d[2] & lvl_q[2];
	wire din      = lvl_q[3];

	// serial frame decode: rw, 7 address bits, 16 data bits
	wire [6:0]  rd_addr = {sh_q[5:0], din};
	wire [6:0]  wr_addr = sh_q[21:15];
	wire [15:0] wr_data = {sh_q[14:0], din};
	wire        wr_stb  = sclk_up & (bit_q == LAST_BIT) & ~rw_q;
	wire        rd_stb  = sclk_up & (bit_q == 5'h07) & sh_q[6];
	wire        srst    = wr_stb & (wr_addr == `ADCC_REG_SRST) & wr_data[`ADCC_SRST_BIT];
	wire we_cfg0 = wr_stb & (wr_addr == `ADCC_REG_CFG0);
	wire we_cfg1 = wr_stb & (wr_addr == `ADCC_REG_CFG1);
	wire we_ovr  = wr_stb & (wr_addr == `ADCC_REG_OVR);
	wire we_corr = wr_stb & (wr_addr == `ADCC_REG_CORR);
	wire we_cor2 = wr_stb & (wr_addr == `ADCC_REG_CORR2);
	wire we_pwr  = wr_stb & (wr_addr == `ADCC_REG_PWR);
	wire we_tpa  = wr_stb & (wr_addr == `ADCC_REG_TPA);
	wire we_tpb  = wr_stb & (wr_addr == `ADCC_REG_TPB);
	wire we_tpc  = wr_stb & (wr_addr == `ADCC_REG_TPC);

	// read-back selection, unmapped offsets read zero
	wire [15:0] rd_data =
		(rd_addr == `ADCC_REG_CFG0)  ? cfg0_q  :
		(rd_addr == `ADCC_REG_CFG1)  ? cfg1_q  :
		(rd_addr == `ADCC_REG_OVR)   ? ovr_q   :
		(rd_addr == `ADCC_REG_CORR)  ? corr_q  :
		(rd_addr == `ADCC_REG_CORR2) ? corr2_q :
		(rd_addr == `ADCC_REG_PWR)   ? pwr_q   :
		(rd_addr == `ADCC_REG_TPA)   ? tpa_q   :
		(rd_addr == `ADCC_REG_TPB)   ? tpb_q   :
		(rd_addr == `ADCC_REG_TPC)   ? tpc_q   : 16'h0000;

	// serial shift engine; read data leaves on falling serial clock edges
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			bit_q       <= 5'h00;
			sh_q        <= '0;
			rw_q        <= 1'b0;
			sdo_q       <= 16'h0000;
			SIF_DOUT    <= 1'b0;
			SIF_DOUT_OE <= 1'b0;
		end else if (!sif_act) begin
			bit_q       <= 5'h00;
			SIF_DOUT_OE <= 1'b0;
		end else begin
			if (sclk_up) begin
				sh_q  <= {sh_q[21:0], din};
				bit_q <= (bit_q > LAST_BIT) ? bit_q : bit_q + 5'h01;  // parks past the frame
				if (bit_q == 5'h00) begin
					rw_q <= din;
				end
			end
			if (rd_stb) begin
				sdo_q       <= rd_data;
				SIF_DOUT_OE <= 1'b1;
			end else if (sclk_dn & SIF_DOUT_OE) begin
				SIF_DOUT <= sdo_q[15];
				sdo_q    <= {sdo_q[14:0], 1'b0};
			end
		end
	end

	// register file; the soft reset write reloads every default and is not stored
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			cfg0_q  <= `ADCC_RST_CFG0;
			cfg1_q  <= `ADCC_RST_CFG1;
			ovr_q   <= `ADCC_RST_OVR;
			corr_q  <= `ADCC_RST_CORR;
			corr2_q <= `ADCC_RST_CORR2;
			pwr_q   <= `ADCC_RST_PWR;
			tpa_q   <= `ADCC_RST_TP;
			tpb_q   <= `ADCC_RST_TP;
			tpc_q   <= `ADCC_RST_TP;
		end else if (srst) begin
			cfg0_q  <= `ADCC_RST_CFG0;
			cfg1_q  <= `ADCC_RST_CFG1;
			ovr_q   <= `ADCC_RST_OVR;
			corr_q  <= `ADCC_RST_CORR;
			corr2_q <= `ADCC_RST_CORR2;
			pwr_q   <= `ADCC_RST_PWR;
			tpa_q   <= `ADCC_RST_TP;
			tpb_q   <= `ADCC_RST_TP;
			tpc_q   <= `ADCC_RST_TP;
		end else begin
			cfg0_q  <= we_cfg0 ? wr_data : cfg0_q;
			cfg1_q  <= we_cfg1 ? wr_data : cfg1_q;
			ovr_q   <= we_ovr  ? wr_data : ovr_q;
			corr_q  <= we_corr ? wr_data : corr_q;
			corr2_q <= we_cor2 ? wr_data : corr2_q;
			pwr_q   <= we_pwr  ? wr_data : pwr_q;
			tpa_q   <= we_tpa  ? wr_data : tpa_q;
			tpb_q   <= we_tpb  ? wr_data : tpb_q;
			tpc_q   <= we_tpc  ? wr_data : tpc_q;
		end
	end

	// control fields
	wire [1:0]  pwr_fld  = pwr_q[`ADCC_PWR_MSB:`ADCC_PWR_LSB];
	wire [3:0]  ovr_thr  = ovr_q[`ADCC_OVR_MSB:`ADCC_OVR_LSB];
	wire        corr_en  = cfg1_q[`ADCC_CFG1_CORR_EN];
	wire        corr_rst = corr_q[`ADCC_CORR_START] | corr2_q[`ADCC_CORR2_RST];
	wire        fmt_ob   = cfg1_q[`ADCC_CFG1_FMT];
	wire        dec_en   = cfg0_q[`ADCC_CFG0_DEC_EN];
	wire        pat_en   = tpa_q[`ADCC_TP_EN];
	wire [11:0] pat_even = tpb_q[`ADCC_TP_MSB:`ADCC_TP_LSB];
	wire [11:0] pat_odd  = tpc_q[`ADCC_TP_MSB:`ADCC_TP_LSB];

	// wake time by chosen state, never below one cycle
	wire [16:0] wake_len =
		(adcc_pwr_t'(pwr_fld) == PWR_SHUTDOWN) ? WAKE_SHUT_CYC :
		(adcc_pwr_t'(pwr_fld) == PWR_STANDBY)  ? WAKE_STBY :
		(adcc_pwr_t'(pwr_fld) == PWR_DEEP)     ? WAKE_DEEP : WAKE_LIGHT;

	// power sequencing: low enable pin enters the chosen state, high pin wakes it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			st_q   <= ST_RUN;
			wake_q <= 17'h00000;
			AWAKE  <= 1'b0;
		end else begin
			case (st_q)
				ST_RUN: begin
					if (!en_pin) st_q <= ST_SLEEP;
				end
				ST_SLEEP: begin
					if (en_pin) begin
						st_q   <= ST_WAKE;
						wake_q <= wake_len - 17'h00001;
					end
				end
				ST_WAKE: begin
					if (!en_pin) st_q <= ST_SLEEP;
					else if (wake_q == 17'h00000) st_q <= ST_RUN;
					else wake_q <= wake_q - 17'h00001;
				end
				default: st_q <= ST_SLEEP;
			endcase
			AWAKE <= (st_q == ST_RUN) & en_pin;
		end
	end

	// pair buffer between the sub-converters and the merger
	adcc_pair_t fifo_out;
	logic       fifo_valid;
	adcc_fifo #(
		.WIDTH ($bits(adcc_pair_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.in_valid  (SUB_VALID & AWAKE),
		.in_data   (SUB_DATA),
		.in_ready  (SUB_READY),
		.out_valid (fifo_valid),
		.out_data  (fifo_out),
		.out_ready (phase_q)
	);

	// interleaving correction: per-lane offset estimate, removed from each result
	wire signed [19:0] est_cur = raw_lane_q ? est_b_q : est_a_q;
	wire signed [19:0] est_nxt = est_cur
		+ (($signed({raw_q, 8'h00}) - est_cur) >>> `ADCC_CORR_SHIFT);
	wire signed [12:0] c_diff  = 13'(raw_q) - 13'($signed(est_cur[19:8]));
	wire signed [11:0] c_sat   = (c_diff > 13'sh07FF) ? 12'sh7FF :
		(c_diff < -13'sh0800) ? -12'sh800 : c_diff[11:0];

	// merge two half-rate lanes, a then b, and correct
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			phase_q    <= 1'b0;
			raw_v_q    <= 1'b0;
			raw_q      <= '0;
			raw_lane_q <= 1'b0;
			c_v_q      <= 1'b0;
			c_q        <= '0;
			est_a_q    <= '0;
			est_b_q    <= '0;
		end else begin
			raw_v_q <= fifo_valid;
			if (fifo_valid) begin
				raw_q      <= phase_q ? fifo_out.b : fifo_out.a;
				raw_lane_q <= phase_q;
				phase_q    <= ~phase_q;
			end
			c_v_q <= raw_v_q;
			c_q   <= corr_en ? c_sat : raw_q;
			if (!corr_en || corr_rst) begin
				est_a_q <= '0;
				est_b_q <= '0;
			end else if (raw_v_q) begin
				est_a_q <= raw_lane_q ? est_a_q : est_nxt;
				est_b_q <= raw_lane_q ? est_nxt : est_b_q;
			end
		end
	end

	// optional decimation filter
	logic               dec_v;
	logic signed [11:0] dec_d;
	adcc_halfband #(
		.W (12)
	) u_dec (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.hpf       (cfg0_q[`ADCC_CFG0_HPF]),
		.in_valid  (c_v_q & dec_en),
		.in_data   (c_q),
		.out_valid (dec_v),
		.out_data  (dec_d)
	);

	wire        s_v = dec_en ? dec_v : c_v_q;
	wire [11:0] s_d = dec_en ? dec_d : c_q;
	wire [11:0] fmt_d = fmt_ob ? {~s_d[11], s_d[10:0]} : s_d;

	// output stage: pattern replaces every sample while selected
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			DOUT       <= 12'h000;
			DOUT_VALID <= 1'b0;
			tog_q      <= 1'b0;
		end else begin
			DOUT_VALID <= s_v;
			if (!pat_en) tog_q <= 1'b0;
			else if (s_v) tog_q <= ~tog_q;
			if (s_v) begin
				DOUT <= pat_en ? (tog_q ? pat_odd : pat_even) : fmt_d;
			end
		end
	end

	// fast over-range: magnitude above threshold times full scale over 16
	wire [11:0] mag  = raw_q[11] ? 12'(-raw_q) : 12'(raw_q);
	wire [11:0] trip_lvl = {1'b0, ovr_thr, 7'h00};
	wire        trip = raw_v_q & (mag > trip_lvl);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ovr_pipe_q <= '0;
			OVR_FLAG   <= 1'b0;
		end else begin
			ovr_pipe_q <= {ovr_pipe_q[`ADCC_OVR_LAT-3:0], trip};
			OVR_FLAG   <= ovr_pipe_q[`ADCC_OVR_LAT-2];
		end
	end
endmodule
`default_nettype wire

// [sim/adcc_rx_model.sv]
// receiver model that captures output samples and over-range flags
`timescale 1ns/100ps
`default_nettype none
module adcc_rx_model (
	// clock
	input  wire logic        clk,
	// sample bus from the converter
	input  wire logic [11:0] dout,
	input  wire logic        dout_valid,
	input  wire logic        ovr_flag
);
	int          cyc = 0;
	logic [11:0] samp[$];
	int          samp_cyc[$];
	int          flag_cyc[$];

	// stamp each sample and each flag with its clock count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dout_valid) begin
			samp.push_back(dout);
			samp_cyc.push_back(cyc);
		end
		if (ovr_flag)
			flag_cyc.push_back(cyc);
	end

	// forget everything captured so far
	task automatic flush();
		samp.delete();
		samp_cyc.delete();
		flag_cyc.delete();
	endtask
endmodule
`default_nettype wire

// [sim/adcc_assertions.sv]
// port-level checks of the converter control
`timescale 1ns/100ps
`default_nettype none
module adcc_chk (
	// watched ports
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic        ENABLE,
	input  wire logic        SIF_EN_N,
	input  wire logic        SIF_DOUT_OE,
	input  wire logic        SUB_VALID,
	input  wire logic        SUB_READY,
	input  wire logic [11:0] DOUT,
	input  wire logic        DOUT_VALID,
	input  wire logic        OVR_FLAG,
	input  wire logic        AWAKE
);
	logic [7:0]  hi_q;
	logic [7:0]  lo_q;
	logic [63:0] push_q;

	// run lengths of the enable pin and a history of taken pairs
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			hi_q   <= 8'hFF;
			lo_q   <= 8'h00;
			push_q <= '0;
		end else begin
			hi_q   <= !ENABLE ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
			lo_q   <= ENABLE ? 8'h00 : (lo_q == 8'hFF ? lo_q : lo_q + 8'h01);
			push_q <= {push_q[62:0], SUB_VALID & SUB_READY & AWAKE};
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	// power pin and wake-up
	a_sleep_on_low: assert property (
		!ENABLE [*8] |-> !AWAKE) else $error("awake with enable low");
	a_fall_cause: assert property (
		$fell(AWAKE) |-> lo_q >= 8'h02) else $error("sleep without enable low");
	a_stay_awake: assert property (
		AWAKE && hi_q >= 8'h08 |=> AWAKE) else $error("left run with enable high");
	a_wake_delay: assert property (
		$rose(AWAKE) |-> hi_q >= 8'h32) else $error("wake-up too early");
	// sample stream and flag
	a_valid_cause: assert property (
		DOUT_VALID |-> |push_q[63:2]) else $error("sample without input");
	a_dout_hold: assert property (
		!DOUT_VALID |-> $stable(DOUT)) else $error("output changed between samples");
	a_ovr_cause: assert property (
		OVR_FLAG |-> |push_q[63:12]) else $error("flag without earlier sample");
	// serial read driver
	a_oe_in_frame: assert property (
		$rose(SIF_DOUT_OE) |-> !SIF_EN_N) else $error("read driver outside frame");
	a_oe_release: assert property (
		SIF_EN_N [*8] |-> !SIF_DOUT_OE) else $error("read driver not released");

	// main scenarios reached
	c_wake: cover property ($rose(AWAKE));
	c_ovr: cover property (OVR_FLAG);
	c_read: cover property ($rose(SIF_DOUT_OE));
endmodule

bind adcc_top adcc_chk chk (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ENABLE(ENABLE), .SIF_EN_N(SIF_EN_N),
	.SIF_DOUT_OE(SIF_DOUT_OE), .SUB_VALID(SUB_VALID), .SUB_READY(SUB_READY),
	.DOUT(DOUT), .DOUT_VALID(DOUT_VALID), .OVR_FLAG(OVR_FLAG), .AWAKE(AWAKE)
);
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of the converter control
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import adcc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n, enable, sif_en_n, sif_clk, din_q, sif_dout, sif_oe;
	logic        sub_valid, sub_ready, dout_valid, ovr, awake;
	adcc_pair_t  sub_data;
	logic [11:0] dout;
	wire logic   sdio;
	int          mismatches = 0;
	int          checks = 0;
	logic [15:0] tp[4][3] = '{'{16'h8000, 16'h0000, 16'h0000},
		'{16'hBFFC, 16'h3FFC, 16'h3FFC}, '{16'h9554, 16'h2AA8, 16'h1554},
		'{16'hBFFC, 16'h0000, 16'h3FFC}};

	// clock and the shared serial data wire
	always #20 clk = ~clk;
	assign sdio = sif_oe ? sif_dout : din_q;

	adcc_top #(.FIFO_DEPTH(16), .WAKE_SHUT_CYC(17'h00064)) dut (
		.CLK_SYS(clk), .RST_N(rst_n), .ENABLE(enable), .SIF_EN_N(sif_en_n),
		.SIF_CLK(sif_clk), .SIF_DIN(sdio), .SIF_DOUT(sif_dout), .SIF_DOUT_OE(sif_oe),
		.SUB_VALID(sub_valid), .SUB_DATA(sub_data), .SUB_READY(sub_ready),
		.DOUT(dout), .DOUT_VALID(dout_valid), .OVR_FLAG(ovr), .AWAKE(awake));
	adcc_rx_model rx (.clk(clk), .dout(dout), .dout_valid(dout_valid), .ovr_flag(ovr));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one serial frame, bits handed over on falling and taken on rising clock
	task automatic sif(input logic rw, input logic [6:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [23:0] f;
		f = {rw, a, d};
		q = '0;
		sif_en_n = 1'b0;
		cyc(8);
		for (int i = 23; i >= 0; i--) begin
			sif_clk = 1'b0;
			din_q = f[i];
			cyc(8);
			q = {q[14:0], sdio};
			sif_clk = 1'b1;
			cyc(8);
		end
		sif_en_n = 1'b1;
		cyc(8);
		sif_clk = 1'b0;
		cyc(8);
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		sif(1'b0, a, d, q);
	endtask

	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		sif(1'b1, a, 16'h0000, q);
		chk(q, exp);
	endtask

	// offer n identical pairs, holding each until it is taken
	task automatic pushn(input int n, input logic [11:0] a, input logic [11:0] b);
		int w;
		sub_valid = 1'b1;
		sub_data = {b, a};
		for (int i = 0; i < n; i++) begin
			w = 0;
			while (!(sub_ready && awake) && w < 200) begin
				cyc(1);
				w++;
			end
			if (w >= 200) begin
				mismatches++;
				$display("[ERR] %0t pair never taken", $time);
			end
			cyc(1);
		end
		sub_valid = 1'b0;
	endtask

	task automatic t_regs();
		rdc(7'h02, 16'h0780);
		rdc(7'h01, 16'h0002);
		rdc(7'h3C, 16'h0000);
		wr(7'h3D, 16'hABCD);
		rdc(7'h3D, 16'hABCD);
		wr(7'h10, 16'hFFFF);
		rdc(7'h10, 16'h0000);
		wr(7'h3D, 16'h0000);
		wr(7'h02, 16'h0100);
		wr(7'h2C, 16'h0001);
		rdc(7'h02, 16'h0780);
		rdc(7'h2C, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_pattern();
		logic [15:0] e;
		for (int p = 0; p < 4; p++) begin
			wr(7'h3C, 16'h0000);
			wr(7'h01, 16'h0000);
			wr(7'h3D, tp[p][1]);
			wr(7'h3E, tp[p][2]);
			wr(7'h3C, tp[p][0]);
			rx.flush();
			pushn(3, 12'h123, 12'h456);
			cyc(30);
			chk(16'(rx.samp.size()), 16'h0006);
			for (int i = 0; i < 6; i++) begin
				e = tp[p][1 + i % 2];
				chk({4'h0, rx.samp[i]}, {4'h0, e[13:2]});
			end
		end
		wr(7'h01, 16'h0002);
		wr(7'h3C, 16'h0000);
		wr(7'h3D, 16'h0000);
		wr(7'h3E, 16'h0000);
		rx.flush();
		pushn(1, 12'h123, 12'hEDC);
		cyc(30);
		chk({4'h0, rx.samp[0]}, 16'h0123);
		chk({4'h0, rx.samp[1]}, 16'h0EDC);
		wr(7'h01, 16'h000A);
		rx.flush();
		pushn(1, 12'h123, 12'hEDC);
		cyc(30);
		chk({4'h0, rx.samp[0]}, 16'h0923);
		chk({4'h0, rx.samp[1]}, 16'h06DC);
		wr(7'h01, 16'h0002);
		$display("test pattern done");
	endtask

	task automatic t_ovr();
		rx.flush();
		pushn(1, 12'h780, 12'h781);
		cyc(40);
		chk(16'(rx.flag_cyc.size()), 16'h0001);
		chk(16'(rx.flag_cyc[0] - rx.samp_cyc[1]), 16'h000A);
		wr(7'h02, 16'h0080);
		rx.flush();
		pushn(1, 12'hF40, 12'h080);
		cyc(40);
		chk(16'(rx.flag_cyc.size()), 16'h0001);
		chk(16'(rx.flag_cyc[0] - rx.samp_cyc[0]), 16'h000A);
		wr(7'h02, 16'h0780);
		$display("test overrange done");
	endtask

	task automatic t_decim();
		for (int h = 0; h < 2; h++) begin
			wr(7'h00, h ? 16'h5000 : 16'h4000);
			rx.flush();
			pushn(8, 12'h100, 12'h100);
			cyc(60);
			chk(16'(rx.samp.size()), 16'h0008);
			chk({4'h0, rx.samp[7]}, h ? 16'h0000 : 16'h0100);
		end
		wr(7'h00, 16'h0000);
		$display("test decimation done");
	endtask

	task automatic t_corr();
		wr(7'h01, 16'h8002);
		wr(7'h03, 16'h4B18);
		rx.flush();
		pushn(4, 12'h100, 12'h100);
		cyc(30);
		chk({4'h0, rx.samp[7]}, 16'h0100);
		wr(7'h03, 16'h0B18);
		wr(7'h1A, 16'h0001);
		wr(7'h1A, 16'h0000);
		rx.flush();
		// a constant input keeps the offset loop within its legal input range
		pushn(128, 12'h100, 12'h100);
		cyc(60);
		chk(16'(rx.samp.size()), 16'h0100);
		chk({15'h0000, rx.samp[255] > 12'h080 && rx.samp[255] < 12'h100}, 16'h0001);
		wr(7'h01, 16'h0002);
		$display("test correction done");
	endtask

	task automatic t_power();
		int lim[4] = '{2500, 50, 500, 100};
		int n;
		for (int m = 0; m < 4; m++) begin
			wr(7'h37, 16'(m));
			rdc(7'h37, 16'(m));
			chk({15'h0000, awake}, 16'h0001);
			enable = 1'b0;
			cyc(20);
			chk({15'h0000, awake}, 16'h0000);
			enable = 1'b1;
			n = 0;
			while (!awake && n < 4000) begin
				cyc(1);
				n++;
			end
			chk({15'h0000, n >= lim[m] && n <= lim[m] + 10}, 16'h0001);
		end
		$display("test power done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial begin
		rst_n = 1'b0;
		enable = 1'b1;
		sif_en_n = 1'b1;
		sif_clk = 1'b0;
		din_q = 1'b0;
		sub_valid = 1'b0;
		sub_data = '0;
		cyc(5);
		rst_n = 1'b1;
		cyc(10);
		t_regs();
		t_pattern();
		t_ovr();
		t_decim();
		t_corr();
		t_power();
		results();
	end

	// watchdog against a hung handshake
	initial begin
		#2400000;
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
